// ### design/cdh_host_port.sv
// Host port, display addressing and cascade link of a character display
//
// Behaviour
// (R1) Register select low picks command register, high picks transfer register.
// (R2) Status read returns busy on bit 7, pointer on bits 0 to 6.
// (R3) Command write loads the command register and starts its execution.
// (R4) Data write stores the byte to text or glyph RAM at pointer.
// (R5) Data read fetches the byte at pointer into transfer register.
// (R6) Command register cannot be read by the host.
// (R7) While busy, busy reads 1 and new commands are ignored.
// (R8) When the operation ends busy clears and commands are accepted.
// (R9) Address command loads pointer and records text or glyph target.
// (R10) Each data read or write steps the pointer up or down by one.
// (R11) Text RAM holds 128 bytes addressed by a 7-bit pointer.
// (R12) Single-line mode shows addresses 00 to 7F at positions 1 to 128.
// (R13) Two-line mode uses 00 to 3F and 40 to 7F per line.
// (R14) Display shift offsets shown addresses by one, wrapping within a line.
// (R15) Master and slave together show 40 characters, slave the later ones.
// (R16) Master drives cascade data, clock and strobe; slave receives them.
// (R17) Cascade data shifts on the falling edge of the cascade clock.
// (R18) Direction select high moves data stage 100 to 1, low 1 to 100.
// (R19) Software selects one of three glyph tables, default English/Japanese.
// (R20) Host polls busy until zero before each new command or data.
// (R21) Graphic column byte has bit 7 set; row byte selects the half.
`timescale 1ns/1ns
`default_nettype none
`include "cdh_defs.svh"
module cdh_host_port
  import cdh_pkg::*;
#(
  parameter int MASTER_CHARS = `CDH_MASTER_CHARS,
  parameter int CASC_HALF    = `CDH_CASC_HALF
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Host pins
  input  wire logic        reg_select,
  input  wire logic        read_not_write,
  input  wire logic        hostEnable,
  input  wire logic [7:0]  hostByteIn,
  output var  logic [7:0]  hostByteOut,
  output var  logic        hostByteOe,
  // Cascade link
  input  wire logic        masterSelect,
  input  wire logic        shift_direction_select,
  input  wire logic        cascDataIn,
  output var  logic        cascDataOut,
  output var  logic        cascDataOe,
  input  wire logic        cascClkIn,
  output var  logic        cascClkOut,
  output var  logic        cascClkOe,
  input  wire logic        cascStrobeIn,
  output var  logic        cascStrobeOut,
  output var  logic        cascStrobeOe,
  // Display side
  output var  logic [99:0] segLatch,
  output var  logic [1:0]  fontTable,
  output var  logic        tallGlyph,
  output var  logic        twoLine,
  output var  logic [6:0]  graphic_column_byte,
  output var  logic        graphic_half_select
);
  localparam int BUSY_CYC =
    (`CDH_BUSY_NS + `CDH_CLK_NS - 1) / `CDH_CLK_NS;

  function automatic logic [6:0] dispAddr(input logic [6:0] pos,
      input logic [6:0] off, input logic two, input logic line);
    logic [6:0] sum;
    sum = pos + off;
    dispAddr = two ? {line, sum[5:0]} : sum;
  endfunction : dispAddr

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [15:0] pinMeta;
  logic [15:0] pinSync;
  logic        ePrev;
  always_ff @(posedge mclk) begin
    pinMeta <= {reg_select, read_not_write, hostEnable, hostByteIn,
                masterSelect, shift_direction_select, cascDataIn,
                cascClkIn, cascStrobeIn};
    pinSync <= pinMeta;
    ePrev   <= rst_n ? pinSync[13] : 1'b0;
  end
  logic       rsS, rwS, eS, msS, shlS, cdS, ccS, csS;
  logic [7:0] busS;
  assign {rsS, rwS, eS, busS, msS, shlS, cdS, ccS, csS} = pinSync;
  logic hostTake;
  assign hostTake = ePrev & ~eS;

  ////////////////////////////////////////////////////////////////////////////
  // Memories
  logic [7:0] textRam  [`CDH_TEXT_DEPTH];
  logic [7:0] glyphRam [`CDH_GLYPH_DEPTH];
  logic       textWe, glyphWe;
  logic [6:0] wrAddr;
  logic [7:0] wrData;
  always_ff @(posedge mclk) begin
    if (textWe) textRam[wrAddr] <= wrData; // R4 R11
    if (glyphWe) glyphRam[wrAddr[5:0]] <= wrData; // R4
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host command and data core
  cdh_state_e state, next_state;
  logic [7:0] command_holding_register, next_cmd;
  logic [7:0] transfer_holding_register, next_xfer;
  logic [6:0] ram_pointer, next_ptr;
  logic [6:0] shiftOff, next_shiftOff;
  logic [7:0] busyCnt, next_busyCnt;
  logic       glyphTarget, next_glyphTarget;
  logic       stepUp, next_stepUp;
  logic       gfxMode, next_gfxMode;
  logic [1:0] next_font;
  logic       next_tall, next_twoLine, next_half;
  logic [6:0] next_column;
  logic [7:0] next_hostOut;
  logic       next_hostOe;
  logic [6:0] stepPtr;

  always_comb begin
    next_state = state;
    next_cmd = command_holding_register;
    next_xfer = transfer_holding_register;
    next_ptr = ram_pointer;
    next_shiftOff = shiftOff;
    next_busyCnt = busyCnt;
    next_glyphTarget = glyphTarget;
    next_stepUp = stepUp;
    next_gfxMode = gfxMode;
    next_font = fontTable;
    next_tall = tallGlyph;
    next_twoLine = twoLine;
    next_half = graphic_half_select;
    next_column = graphic_column_byte;
    textWe = 1'b0;
    glyphWe = 1'b0;
    wrAddr = ram_pointer;
    wrData = busS;
    stepPtr = stepUp ? ram_pointer + 7'h01 : ram_pointer - 7'h01;
    if (glyphTarget) stepPtr[6] = 1'b0;
    unique case (state)
      CDH_IDLE: begin
        if (hostTake && !rwS) begin
          next_state = CDH_BUSY;
          next_busyCnt = 8'(BUSY_CYC);
          if (!rsS) begin
            next_cmd = busS; // R3 R1 R6
            if (gfxMode && busS[7]) begin
              next_column = busS[6:0]; // R21
            end else if (gfxMode &&
                (busS & `CDH_ROW_MASK) == `CDH_ROW_CODE) begin
              next_half = busS[0]; // R21
            end else if (busS[`CDH_TEXT_ADDR_BIT]) begin
              next_ptr = busS[6:0]; // R9
              next_glyphTarget = 1'b0; // R9
            end else if ((busS & `CDH_GLYPH_MASK) == `CDH_GLYPH_CODE) begin
              next_ptr = {1'b0, busS[5:0]}; // R9
              next_glyphTarget = 1'b1; // R9
            end else if ((busS & `CDH_FUNC_MASK) == `CDH_FUNC_CODE) begin
              next_gfxMode = busS[`CDH_FUNC_GFX];
              next_twoLine = busS[`CDH_FUNC_LINES]; // R12 R13
              next_tall = busS[`CDH_FUNC_TALL]; // R19
              next_font = busS[1:0]; // R19
            end else if ((busS & `CDH_SHIFT_MASK) == `CDH_SHIFT_CODE) begin
              if (busS[`CDH_SHIFT_DISP]) begin
                next_shiftOff = busS[`CDH_SHIFT_RIGHT] ?
                  shiftOff - 7'h01 : shiftOff + 7'h01; // R14
              end else begin
                next_ptr = busS[`CDH_SHIFT_RIGHT] ?
                  ram_pointer + 7'h01 : ram_pointer - 7'h01;
              end
            end else if ((busS & `CDH_ENTRY_MASK) == `CDH_ENTRY_CODE) begin
              next_stepUp = busS[`CDH_ENTRY_INC_BIT];
            end else if (busS == `CDH_CMD_HOME) begin
              next_ptr = 7'h00;
              next_shiftOff = 7'h00;
              next_glyphTarget = 1'b0;
            end
          end else begin
            next_xfer = busS; // R4
            textWe = !glyphTarget; // R4
            glyphWe = glyphTarget; // R4
            next_ptr = stepPtr; // R10
          end
        end else if (hostTake && rsS) begin
          next_state = CDH_BUSY;
          next_busyCnt = 8'(BUSY_CYC);
          next_ptr = stepPtr; // R10 R5
        end
      end
      CDH_BUSY: begin
        next_busyCnt = busyCnt - 8'h01; // R7
        if (busyCnt == 8'h01) begin
          next_state = CDH_IDLE; // R8
          next_xfer = glyphTarget ? glyphRam[ram_pointer[5:0]]
                                  : textRam[ram_pointer]; // R5
        end
      end
    endcase
    next_hostOe = eS & rwS;
    next_hostOut = rsS ? transfer_holding_register // R5
                       : {state == CDH_BUSY, ram_pointer}; // R2
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state <= CDH_IDLE;
      command_holding_register <= 8'h00;
      transfer_holding_register <= 8'h00;
      ram_pointer <= 7'h00;
      shiftOff <= 7'h00;
      busyCnt <= 8'h00;
      glyphTarget <= 1'b0;
      stepUp <= 1'b1;
      gfxMode <= 1'b0;
      fontTable <= `CDH_FONT_RESET; // R19
      tallGlyph <= 1'b0;
      twoLine <= 1'b0;
      graphic_half_select <= 1'b0;
      graphic_column_byte <= 7'h00;
      hostByteOut <= 8'h00;
      hostByteOe <= 1'b0;
    end else begin
      state <= next_state;
      command_holding_register <= next_cmd;
      transfer_holding_register <= next_xfer;
      ram_pointer <= next_ptr;
      shiftOff <= next_shiftOff;
      busyCnt <= next_busyCnt;
      glyphTarget <= next_glyphTarget;
      stepUp <= next_stepUp;
      gfxMode <= next_gfxMode;
      fontTable <= next_font;
      tallGlyph <= next_tall;
      twoLine <= next_twoLine;
      graphic_half_select <= next_half;
      graphic_column_byte <= next_column;
      hostByteOut <= next_hostOut;
      hostByteOe <= next_hostOe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cascade link
  logic [99:0] shiftReg, next_shiftReg, next_seg;
  logic [7:0]  divCnt, next_divCnt;
  logic [6:0]  bitIdx, next_bitIdx;
  logic        scanLine, next_scanLine;
  logic        ccPrev, csPrev;
  logic        next_cdOut, next_ccOut, next_csOut, shiftNow, shiftBit;
  logic [6:0]  genAddr;
  logic [7:0]  genByte;

  always_comb begin
    next_shiftReg = shiftReg;
    next_seg = segLatch;
    next_divCnt = divCnt;
    next_bitIdx = bitIdx;
    next_scanLine = scanLine;
    next_cdOut = cascDataOut;
    next_ccOut = cascClkOut;
    next_csOut = cascStrobeOut;
    genAddr = dispAddr(7'(MASTER_CHARS) + 7'(bitIdx[6:3]), shiftOff,
                       twoLine, scanLine); // R12 R13 R14 R15
    genByte = textRam[genAddr];
    shiftNow = 1'b0;
    shiftBit = cdS;
    if (msS) begin
      next_divCnt = divCnt + 8'h01;
      if (divCnt == 8'(CASC_HALF - 1)) begin
        next_divCnt = 8'h00;
        next_ccOut = ~cascClkOut;
        if (cascClkOut) begin
          shiftNow = 1'b1; // R17
          shiftBit = cascDataOut;
          next_csOut = 1'b0;
          next_bitIdx = bitIdx + 7'h01;
          if (bitIdx == 7'(`CDH_STAGES - 1)) begin
            next_bitIdx = 7'h00;
            next_csOut = 1'b1;
            next_scanLine = twoLine & ~scanLine; // R13
          end
        end else begin
          next_cdOut = genByte[bitIdx[2:0]];
        end
      end
    end else begin
      next_ccOut = 1'b0;
      next_csOut = 1'b0;
      next_cdOut = 1'b0;
      shiftNow = ccPrev & ~ccS; // R17 R16
    end
    if (shiftNow) begin
      next_shiftReg = shlS ? {shiftBit, shiftReg[99:1]}
                           : {shiftReg[98:0], shiftBit}; // R18
    end
    if ((msS && next_csOut && !cascStrobeOut) || (!msS && csS && !csPrev))
      next_seg = next_shiftReg; // R15
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      shiftReg <= '0;
      segLatch <= '0;
      divCnt <= 8'h00;
      bitIdx <= 7'h00;
      scanLine <= 1'b0;
      ccPrev <= 1'b0;
      csPrev <= 1'b0;
      cascDataOut <= 1'b0;
      cascClkOut <= 1'b0;
      cascStrobeOut <= 1'b0;
      cascDataOe <= 1'b0;
      cascClkOe <= 1'b0;
      cascStrobeOe <= 1'b0;
    end else begin
      shiftReg <= next_shiftReg;
      segLatch <= next_seg;
      divCnt <= next_divCnt;
      bitIdx <= next_bitIdx;
      scanLine <= next_scanLine;
      ccPrev <= ccS;
      csPrev <= csS;
      cascDataOut <= next_cdOut;
      cascClkOut <= next_ccOut;
      cascStrobeOut <= next_csOut;
      cascDataOe <= msS; // R16
      cascClkOe <= msS; // R16
      cascStrobeOe <= msS; // R16
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  AST_STATUS_WORD: assert property (@(posedge mclk) disable iff (!rst_n) // R2
    eS && rwS && !rsS |=> hostByteOut == {$past(state == CDH_BUSY),
                                           $past(ram_pointer)})
    else $error("status word wrong");
  AST_CMD_LOAD: assert property (@(posedge mclk) disable iff (!rst_n) // R3
    state == CDH_IDLE && hostTake && !rwS && !rsS
      |=> command_holding_register == $past(busS) && state == CDH_BUSY)
    else $error("command not loaded");
  AST_BUSY_IGNORE: assert property (@(posedge mclk) disable iff (!rst_n) // R7
    state == CDH_BUSY && busyCnt > 8'h01 |=> $stable(command_holding_register))
    else $error("command taken while busy");
  AST_BUSY_ENDS: assert property (@(posedge mclk) disable iff (!rst_n) // R8
    $rose(state == CDH_BUSY) |-> ##6 state == CDH_IDLE)
    else $error("busy does not end in time");
  AST_PTR_STEP: assert property (@(posedge mclk) disable iff (!rst_n) // R10
    state == CDH_IDLE && hostTake && rsS && !glyphTarget
      |=> ram_pointer == ($past(stepUp) ? $past(ram_pointer) + 7'h01
                                        : $past(ram_pointer) - 7'h01))
    else $error("pointer did not step");
  AST_ADDR_SET: assert property (@(posedge mclk) disable iff (!rst_n) // R9
    state == CDH_IDLE && hostTake && !rwS && !rsS && busS[7] && !gfxMode
      |=> ram_pointer == $past(busS[6:0]) && !glyphTarget)
    else $error("address set failed");
  AST_OE_MODE: assert property (@(posedge mclk) disable iff (!rst_n) // R16
    !msS [*2] |-> !cascClkOe && !cascDataOe && !cascStrobeOe)
    else $error("slave drives cascade pins");
  AST_SLAVE_SHIFT: assert property (@(posedge mclk) disable iff (!rst_n) // R18
    !msS && ccPrev && !ccS && shlS |=> shiftReg[99] == $past(cdS))
    else $error("slave shift wrong");
  AST_WRITE_STORE: assert property (@(posedge mclk) disable iff (!rst_n) // R4
    state == CDH_IDLE && hostTake && !rwS && rsS && !glyphTarget
      |=> textRam[$past(ram_pointer)] == $past(busS))
    else $error("data not stored");
endmodule : cdh_host_port
`default_nettype wire

// ### design/cdh_defs.svh
// Constants of the character display host port
`ifndef CDH_DEFS_SVH
`define CDH_DEFS_SVH

// Timing
`define CDH_CLK_NS        100
`define CDH_BUSY_NS       600
`define CDH_CASC_HALF     4

// Sizes
`define CDH_TEXT_DEPTH    128
`define CDH_GLYPH_DEPTH   64
`define CDH_STAGES        100
`define CDH_MASTER_CHARS  8

// Status word fields
`define CDH_BUSY_BIT      7

// Command codes and fields
`define CDH_CMD_HOME      8'h01
`define CDH_ENTRY_MASK    8'hfc
`define CDH_ENTRY_CODE    8'h04
`define CDH_ENTRY_INC_BIT 1
`define CDH_SHIFT_MASK    8'hf0
`define CDH_SHIFT_CODE    8'h10
`define CDH_SHIFT_DISP    3
`define CDH_SHIFT_RIGHT   2
`define CDH_FUNC_MASK     8'he0
`define CDH_FUNC_CODE     8'h20
`define CDH_FUNC_GFX      4
`define CDH_FUNC_LINES    3
`define CDH_FUNC_TALL     2
`define CDH_TEXT_ADDR_BIT 7
`define CDH_GLYPH_MASK    8'hc0
`define CDH_GLYPH_CODE    8'h40
`define CDH_ROW_MASK      8'hfe
`define CDH_ROW_CODE      8'h40

// Reset values
`define CDH_FONT_RESET    2'h0
`define CDH_SPACE_CODE    8'h20

`endif

// ### design/cdh_pkg.sv
// Types of the character display host port
package cdh_pkg;
  typedef enum logic [1:0] {
    CDH_IDLE = 2'b01,
    CDH_BUSY = 2'b10
  } cdh_state_e;
  typedef enum logic [1:0] {
    CDH_FONT_ENG_JAP = 2'h0,
    CDH_FONT_WEST_EU = 2'h1,
    CDH_FONT_ENG_RUS = 2'h2
  } cdh_font_e;
endpackage : cdh_pkg

// ### bench/cdh_host_model.sv
// Host processor model driving the parallel host bus
`timescale 1ns/1ns
`default_nettype none
module cdh_host_model (
  // Clock
  input  wire logic       mclk,
  // Host pins
  output var  logic       regSel,
  output var  logic       rdNotWr,
  output var  logic       strobe,
  output var  logic [7:0] busLevel,
  input  wire logic [7:0] hostByteOut,
  input  wire logic       hostByteOe,
  // Checked read results
  output var  logic       rdValid,
  output var  logic [7:0] rdByte
);
  logic [7:0] drv;
  logic       drvOn;

  // Released bus shows the inverse of the last byte
  assign busLevel = hostByteOe ? hostByteOut : (drvOn ? drv : ~drv);

  initial begin
    regSel = 1'b0;
    rdNotWr = 1'b1;
    strobe = 1'b0;
    drv = 8'h00;
    drvOn = 1'b0;
    rdValid = 1'b0;
    rdByte = 8'h00;
  end

  //////////////////////////////////////////////////////////////////////////////
  // One strobe cycle; reads wait for the device to drive
  task automatic access(input logic rs, input logic rw, input logic [7:0] wd,
                        input logic chk, output logic [7:0] rd);
    int n;
    n = 0;
    @(posedge mclk);
    regSel <= rs;
    rdNotWr <= rw;
    drv <= wd;
    drvOn <= !rw;
    strobe <= 1'b1;
    @(posedge mclk);
    while (rw && hostByteOe !== 1'b1 && n < 20) begin
      @(posedge mclk);
      n++;
    end
    @(posedge mclk);
    rd = hostByteOut;
    strobe <= 1'b0;
    rdByte <= rd;
    rdValid <= chk;
    @(posedge mclk);
    rdValid <= 1'b0;
    @(posedge mclk);
    drvOn <= 1'b0;
  endtask : access
endmodule : cdh_host_model
`default_nettype wire

// ### bench/test_cdh_host_port.sv
// Self-checking bench of the character display host port
`timescale 1ns/1ns
`default_nettype none
module test_cdh_host_port;
  logic         mclk;
  logic         rst_n;
  logic         regSel;
  logic         rdNotWr;
  logic         strobe;
  logic [7:0]   busLevel;
  logic [7:0]   hostByteOut;
  logic         hostByteOe;
  logic         rdValid;
  logic [7:0]   rdByte;
  logic         masterSel;
  logic         shDir;
  logic         cData;
  logic         cClk;
  logic         cStrobe;
  logic         cascClkOe;
  logic [99:0]  segLatch;
  logic [1:0]   fontTable;
  logic         tallGlyph;
  logic         twoLine;
  logic [6:0]   gCol;
  logic         gHalf;
  logic [7:0]   d;
  logic [7:0]   wb [3];
  logic [7:0]   expQ [$];
  logic [1:0]   fv;
  logic [31:0]  rng = 32'hcbe0;
  int           badCount = 0;
  int           numChecks = 0;
  int           cyc = 0;

  cdh_host_port cdh_host_port_inst (
    .mclk(mclk), .rst_n(rst_n), .reg_select(regSel),
    .read_not_write(rdNotWr), .hostEnable(strobe), .hostByteIn(busLevel),
    .hostByteOut(hostByteOut), .hostByteOe(hostByteOe),
    .masterSelect(masterSel), .shift_direction_select(shDir),
    .cascDataIn(cData), .cascDataOut(), .cascDataOe(),
    .cascClkIn(cClk), .cascClkOut(), .cascClkOe(cascClkOe),
    .cascStrobeIn(cStrobe), .cascStrobeOut(), .cascStrobeOe(),
    .segLatch(segLatch), .fontTable(fontTable), .tallGlyph(tallGlyph),
    .twoLine(twoLine), .graphic_column_byte(gCol),
    .graphic_half_select(gHalf)
  );
  cdh_host_model cdh_host_model_inst (
    .mclk(mclk), .regSel(regSel), .rdNotWr(rdNotWr), .strobe(strobe),
    .busLevel(busLevel), .hostByteOut(hostByteOut),
    .hostByteOe(hostByteOe), .rdValid(rdValid), .rdByte(rdByte)
  );

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(string nm, logic [99:0] e, logic [99:0] s);
    numChecks++;
    if (s !== e) begin
      $display("Error %s expected %h seen %h", nm, e, s);
      badCount++;
    end
  endtask : chk
  task automatic testDone;
    $display("checks %0d mismatches %0d", numChecks, badCount);
    if (badCount == 0 && numChecks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : testDone
  task automatic endTest(string nm);
    $display("test %s done", nm);
  endtask : endTest
  function automatic logic [31:0] xs(logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  task automatic poll;
    int n;
    n = 0;
    d = 8'hff;
    while (d[7] !== 1'b0 && n < 30) begin
      cdh_host_model_inst.access(1'b0, 1'b1, 8'h00, 1'b0, d);
      n++;
    end
  endtask : poll
  task automatic cmd(logic [7:0] c);
    cdh_host_model_inst.access(1'b0, 1'b0, c, 1'b0, d);
    poll();
  endtask : cmd
  task automatic wr(logic [7:0] b);
    cdh_host_model_inst.access(1'b1, 1'b0, b, 1'b0, d);
    poll();
  endtask : wr
  task automatic rdChk(logic rs, logic [7:0] e);
    expQ.push_back(e);
    cdh_host_model_inst.access(rs, 1'b1, 8'h00, 1'b1, d);
    poll();
  endtask : rdChk
  // Slave frame: one marked bit then zeros, clock idle low outside
  task automatic frame(logic dir);
    shDir <= dir;
    for (int i = 0; i < 100; i++) begin
      cData <= (i == 0);
      repeat (2) @(posedge mclk);
      cClk <= 1'b1;
      repeat (4) @(posedge mclk);
      cClk <= 1'b0;
      repeat (2) @(posedge mclk);
    end
    repeat (4) @(posedge mclk);
    cStrobe <= 1'b1;
    repeat (4) @(posedge mclk);
    cStrobe <= 1'b0;
    cData <= 1'b1;
    repeat (6) @(posedge mclk);
  endtask : frame

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (rdValid === 1'b1) begin
      if (expQ.size() == 0)
        chk("queue", 1, 0);
      else
        chk("hostByte", expQ.pop_front(), rdByte);
    end
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 30000) begin
      badCount++;
      testDone();
    end
  end

  initial begin
    rst_n = 1'b0;
    masterSel = 1'b0;
    shDir = 1'b0;
    cData = 1'b0;
    cClk = 1'b0;
    cStrobe = 1'b0;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    rdChk(1'b0, 8'h00);
    chk("font", 0, fontTable);
    chk("oe", 0, cascClkOe);
    endTest("reset");
    cdh_host_model_inst.access(1'b0, 1'b0, 8'h85, 1'b0, d);
    cdh_host_model_inst.access(1'b0, 1'b0, 8'h8a, 1'b0, d);
    poll();
    rdChk(1'b0, 8'h05);
    endTest("busy");
    cmd(8'hfe);
    for (int i = 0; i < 3; i++) begin
      rng = xs(rng);
      wb[i] = rng[7:0];
      wr(wb[i]);
    end
    rdChk(1'b0, 8'h01);
    cmd(8'hfe);
    for (int i = 0; i < 3; i++)
      rdChk(1'b1, wb[i]);
    rdChk(1'b0, 8'h01);
    cmd(8'h04);
    cmd(8'h90);
    wr(8'h3c);
    wr(8'hc3);
    rdChk(1'b0, 8'h0e);
    cmd(8'h06);
    cmd(8'h01);
    rdChk(1'b0, 8'h00);
    endTest("data");
    cmd(8'h7f);
    wr(8'h15);
    rdChk(1'b0, 8'h00);
    cmd(8'h7f);
    rdChk(1'b1, 8'h15);
    cmd(8'hff);
    rdChk(1'b1, wb[1]);
    endTest("glyph");
    for (int f = 0; f < 3; f++) begin
      fv = 2'(f);
      cmd({3'b001, 1'b0, fv[0], fv[1], fv});
      chk("font", fv, fontTable);
      chk("lines", fv[0], twoLine);
      chk("tall", fv[1], tallGlyph);
    end
    cmd(8'h30);
    cmd(8'hcb);
    cmd(8'h41);
    chk("column", 8'h4b, gCol);
    chk("half", 1, gHalf);
    cmd(8'h40);
    chk("half", 0, gHalf);
    cmd(8'h20);
    endTest("modes");
    frame(1'b0);
    chk("latch", {1'b1, 99'h0}, segLatch);
    frame(1'b1);
    chk("latch", 100'h1, segLatch);
    cmd(8'h18);
    masterSel <= 1'b1;
    repeat (5) @(posedge mclk);
    chk("oe", 1, cascClkOe);
    repeat (1700) @(posedge mclk);
    chk("master", {8'h3c, 8'hc3}, segLatch[63:48]);
    endTest("cascade");
    testDone();
  end
endmodule : test_cdh_host_port
`default_nettype wire
